// ### hw/aosc_device.sv
/*
 * Configuration register bank of a dual converter: serialization mode,
 * committed resolution/rate override, I/O pull-down and common-mode control,
 * soft reset and power mode with digital datapath reset.
 * Assumes a host on aosc_link_if sharing core_clk_in.
 */
// Functional notes
// - Override writes wait for transfer bit commit
// - Override low bits cap rate capability only
// - Pull-down off bit disables data pin pull-down
// - Common-mode power-down bit stops generator
// - Serialization register resets to 12-bit DDR bytewise
// - Serialization value decodes width, frame, lane layout
// - Data clock multiple follows width and layout
// - Soft reset then digital reset recovers device
// - Digital reset reruns init after clock stable
// - Host digital resets after late common-mode
// - Host moves link only on request; user keeps it quiet during critical sampling
// - Other registers take effect when written
// - Digital reset clears datapath, not register port
`timescale 1ns/1ps
`include "aosc_params.svh"

module aosc_device
	import aosc_pkg::*;
	(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	aosc_link_if.device link,
	output logic [7:0] rate_override_out,
	output logic [2:0] rate_cap_out,
	output logic sdio_pulldown_en_out,
	output logic vcm_powerdown_out,
	output logic sample_is_12bit_out,
	output logic frame_2x_out,
	output aosc_lane_t lane_mode_out,
	output logic [3:0] clk_mult_x2_out,
	output aosc_power_t power_mode_out,
	output logic datapath_reset_out,
	output logic datapath_enable_out,
	output logic init_done_out
	);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	aosc_byte_t serial_output_mode;
	// Pending and committed override copies stay apart until the transfer strobe
	aosc_byte_t resolution_rate_override;
	aosc_byte_t override_active;
	logic user_io_control_two;
	logic user_io_control_three;
	logic [1:0] power_mode;
	logic init_done;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire logic hit_config = (link.addr == `AOSC_OFS_CONFIG);
	wire logic hit_power = (link.addr == `AOSC_OFS_POWER_MODE);
	wire logic hit_serial = (link.addr == `AOSC_OFS_SERIAL_MODE);
	wire logic hit_transfer = (link.addr == `AOSC_OFS_TRANSFER);
	wire logic hit_override = (link.addr == `AOSC_OFS_OVERRIDE);
	wire logic hit_io_two = (link.addr == `AOSC_OFS_IO_CTRL_TWO);
	wire logic hit_io_three = (link.addr == `AOSC_OFS_IO_CTRL_THREE);

	// Command registers have no storage; they only act in the cycle they are written
	wire logic wr_serial = link.wr_en && hit_serial;
	wire logic wr_override = link.wr_en && hit_override;
	wire logic wr_io_two = link.wr_en && hit_io_two;
	wire logic wr_io_three = link.wr_en && hit_io_three;
	wire logic wr_power = link.wr_en && hit_power;
	// Soft reset only on the exact pattern; other values are ignored
	wire logic soft_reset = link.wr_en && hit_config && (link.wr_data == `AOSC_SOFT_RESET_VAL);
	wire logic commit = link.wr_en && hit_transfer && link.wr_data[`AOSC_TRANSFER_BIT];

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || soft_reset) begin
			serial_output_mode <= `AOSC_RST_SERIAL_MODE;
			resolution_rate_override <= `AOSC_RST_ZERO;
			override_active <= `AOSC_RST_ZERO;
			user_io_control_two <= 1'b0;
			user_io_control_three <= 1'b0;
			power_mode <= 2'h0;
		end else begin
			if (wr_serial) begin
				serial_output_mode <= link.wr_data;
			end
			if (wr_override) begin
				resolution_rate_override <= link.wr_data;
			end
			// A write to the override in the commit cycle is picked up by the next commit
			if (commit) begin
				override_active <= resolution_rate_override;
			end
			if (wr_io_two) begin
				user_io_control_two <= link.wr_data[`AOSC_PULLDOWN_OFF_BIT];
			end
			if (wr_io_three) begin
				user_io_control_three <= link.wr_data[`AOSC_VCM_PD_BIT];
			end
			if (wr_power) begin
				power_mode <= link.wr_data[`AOSC_POWER_MSB:0];
			end
		end
	end

	// ****************************************************************
	// Initialization state
	// ****************************************************************
	// Init reruns on every digital reset, which is how a bad power-up recovers
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			init_done <= 1'b0;
		end else if (power_mode == 2'h3) begin
			init_done <= 1'b0;
		end else begin
			init_done <= 1'b1;
		end
	end

	// ****************************************************************
	// Read back
	// ****************************************************************
	// Open bits and command registers read back as zero
	wire aosc_byte_t rd_mux =
		hit_power ? {6'h00, power_mode} :
		hit_serial ? serial_output_mode :
		hit_override ? resolution_rate_override :
		hit_io_two ? {7'h00, user_io_control_two} :
		hit_io_three ? {4'h0, user_io_control_three, 3'h0} :
		8'h00;

	// The register port is never held in digital reset
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			link.rd_data <= 8'h00;
			link.rd_valid <= 1'b0;
		end else begin
			link.rd_data <= link.rd_en ? rd_mux : 8'h00;
			link.rd_valid <= link.rd_en;
		end
	end

	// ****************************************************************
	// Serialization decode
	// ****************************************************************
	wire logic [3:0] low_nib = serial_output_mode[3:0];
	wire logic [3:0] high_nib = serial_output_mode[7:4];
	wire logic width_12 = (low_nib == 4'h2) || (low_nib == 4'h6);
	wire logic frame_2x = (low_nib == 4'h6) || (low_nib == 4'h7);
	// Nibbles outside the table map to an invalid layout instead of a guess
	aosc_lane_t lane;
	assign lane =
		(high_nib == `AOSC_SER_LAYOUT_BDDR2) ? AOSC_LANE_DDR_BYTE :
		(high_nib == `AOSC_SER_LAYOUT_TDDR2) ? AOSC_LANE_DDR_BIT :
		(high_nib == `AOSC_SER_LAYOUT_BSDR2) ? AOSC_LANE_SDR_BYTE :
		(high_nib == `AOSC_SER_LAYOUT_TSDR2) ? AOSC_LANE_SDR_BIT :
		(high_nib == `AOSC_SER_LAYOUT_DDR1) ? AOSC_LANE_DDR_WORD :
		AOSC_LANE_INVALID;
	wire logic lane_ddr2 = (lane == AOSC_LANE_DDR_BYTE) || (lane == AOSC_LANE_DDR_BIT);
	// Multiplier is twice the sample-rate multiple so 2.5x stays integer
	wire logic [3:0] mult =
		lane_ddr2 ? (width_12 ? `AOSC_CLK_MULT_3X : `AOSC_CLK_MULT_2P5X) :
		(width_12 ? `AOSC_CLK_MULT_6X : `AOSC_CLK_MULT_5X);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Registered so a decode change never glitches into the datapath
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rate_override_out <= 8'h00;
			rate_cap_out <= 3'h0;
			sdio_pulldown_en_out <= 1'b1;
			vcm_powerdown_out <= 1'b0;
			sample_is_12bit_out <= 1'b1;
			frame_2x_out <= 1'b0;
			lane_mode_out <= AOSC_LANE_DDR_BYTE;
			clk_mult_x2_out <= `AOSC_CLK_MULT_3X;
			power_mode_out <= AOSC_PWR_ON;
			datapath_reset_out <= 1'b1;
			datapath_enable_out <= 1'b0;
		end else begin
			rate_override_out <= override_active;
			// Caps capability; the sampling clock itself is not touched here
			rate_cap_out <= override_active[`AOSC_RATE_CAP_MSB:0];
			sdio_pulldown_en_out <= !user_io_control_two;
			vcm_powerdown_out <= user_io_control_three;
			sample_is_12bit_out <= width_12;
			frame_2x_out <= frame_2x;
			lane_mode_out <= lane;
			clk_mult_x2_out <= mult;
			power_mode_out <= aosc_power_t'(power_mode);
			// Power-down also holds the datapath in reset; standby only stops it
			datapath_reset_out <= (power_mode == 2'h3) || (power_mode == 2'h1);
			datapath_enable_out <= (power_mode == 2'h0) && init_done;
		end
	end

	assign init_done_out = init_done;

endmodule // aosc_device

// ### hw/aosc_host.sv
/*
 * Host end: issues single register accesses and the recovery sequences
 * (soft reset then digital reset, or digital reset alone).
 * Assumes the device on aosc_link_if sharing core_clk_in.
 */
`timescale 1ns/1ps
`include "aosc_params.svh"

module aosc_host
	import aosc_pkg::*;
	(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	aosc_link_if.host link,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [`AOSC_ADDR_W-1:0] req_addr_in,
	input wire logic [7:0] req_data_in,
	input wire logic recover_supply_in,
	input wire logic recover_clock_in,
	output logic req_ready_out,
	output logic [7:0] rsp_data_out,
	output logic rsp_valid_out
	);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	aosc_host_state_t state;
	aosc_host_state_t next_state;
	logic wr_en;
	logic rd_en;
	aosc_addr_t addr;
	aosc_byte_t wr_data;

	assign req_ready_out = (state == AOSC_H_IDLE);

	always_comb begin
		next_state = state;
		case (state)
			AOSC_H_IDLE: begin
				// Recovery takes priority over a plain access
				if (recover_supply_in) begin
					next_state = AOSC_H_SOFT;
				end else if (recover_clock_in) begin
					next_state = AOSC_H_DIGRST;
				end else if (req_valid_in) begin
					next_state = AOSC_H_SINGLE;
				end
			end
			AOSC_H_SOFT: next_state = AOSC_H_DIGRST;
			AOSC_H_DIGRST: next_state = AOSC_H_NORMAL;
			default: next_state = AOSC_H_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state <= AOSC_H_IDLE;
			wr_en <= 1'b0;
			rd_en <= 1'b0;
			addr <= `AOSC_OFS_CONFIG;
			wr_data <= 8'h00;
		end else begin
			state <= next_state;
			wr_en <= (next_state != AOSC_H_IDLE) && !((next_state == AOSC_H_SINGLE) && !req_write_in);
			rd_en <= (next_state == AOSC_H_SINGLE) && !req_write_in;
			case (next_state)
				AOSC_H_SOFT: begin
					addr <= `AOSC_OFS_CONFIG;
					wr_data <= `AOSC_SOFT_RESET_VAL;
				end
				AOSC_H_DIGRST: begin
					addr <= `AOSC_OFS_POWER_MODE;
					wr_data <= `AOSC_PWR_DIG_RESET;
				end
				AOSC_H_NORMAL: begin
					addr <= `AOSC_OFS_POWER_MODE;
					wr_data <= `AOSC_PWR_NORMAL;
				end
				AOSC_H_SINGLE: begin
					addr <= req_addr_in;
					wr_data <= req_data_in;
				end
				default: begin
					addr <= addr;
					wr_data <= wr_data;
				end
			endcase
		end
	end

	// The link only moves when the user asks; keep requests off critical windows
	assign link.wr_en = wr_en;
	assign link.rd_en = rd_en;
	assign link.addr = addr;
	assign link.wr_data = wr_data;

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rsp_data_out <= 8'h00;
			rsp_valid_out <= 1'b0;
		end else begin
			rsp_valid_out <= link.rd_valid;
			rsp_data_out <= link.rd_valid ? link.rd_data : rsp_data_out;
		end
	end

endmodule // aosc_host

// ### hw/aosc_link_if.sv
/*
 * Register access link between host and converter configuration bank.
 * Assumes one shared clock; a write is one cycle of wr_en, a read returns
 * rd_data in the cycle after rd_en.
 */
`timescale 1ns/1ps

interface aosc_link_if
	import aosc_pkg::*;
	(input wire logic clk);

	logic wr_en;
	logic rd_en;
	aosc_addr_t addr;
	aosc_byte_t wr_data;
	aosc_byte_t rd_data;
	logic rd_valid;

	modport device (
		input wr_en, rd_en, addr, wr_data,
		output rd_data, rd_valid
	);

	modport host (
		output wr_en, rd_en, addr, wr_data,
		input rd_data, rd_valid
	);

endinterface

// ### hw/aosc_params.svh
/*
 * Register offsets, field positions, reset values and command values of the
 * converter configuration register bank.
 * Assumes inclusion by bare name from the package and both end modules.
 */
`ifndef AOSC_PARAMS_SVH
`define AOSC_PARAMS_SVH

`define AOSC_ADDR_W 13
`define AOSC_OFS_CONFIG 13'h000
`define AOSC_OFS_POWER_MODE 13'h008
`define AOSC_OFS_SERIAL_MODE 13'h021
`define AOSC_OFS_TRANSFER 13'h0FF
`define AOSC_OFS_OVERRIDE 13'h100
`define AOSC_OFS_IO_CTRL_TWO 13'h101
`define AOSC_OFS_IO_CTRL_THREE 13'h102

`define AOSC_RST_SERIAL_MODE 8'h32
`define AOSC_RST_ZERO 8'h00
`define AOSC_SOFT_RESET_VAL 8'h3C
`define AOSC_PWR_DIG_RESET 8'h03
`define AOSC_PWR_NORMAL 8'h00

`define AOSC_TRANSFER_BIT 0
`define AOSC_PULLDOWN_OFF_BIT 0
`define AOSC_VCM_PD_BIT 3
`define AOSC_RATE_CAP_MSB 2
`define AOSC_POWER_MSB 1

`define AOSC_SER_LAYOUT_BDDR2 4'h3
`define AOSC_SER_LAYOUT_TDDR2 4'h2
`define AOSC_SER_LAYOUT_BSDR2 4'h1
`define AOSC_SER_LAYOUT_TSDR2 4'h0
`define AOSC_SER_LAYOUT_DDR1 4'h4

`define AOSC_CLK_MULT_3X 4'h6
`define AOSC_CLK_MULT_6X 4'hC
`define AOSC_CLK_MULT_2P5X 4'h5
`define AOSC_CLK_MULT_5X 4'hA

`endif

// ### hw/aosc_pkg.sv
/*
 * Types shared by the configuration register bank and its host end.
 * Assumes aosc_params.svh is on the include path.
 */
`include "aosc_params.svh"

package aosc_pkg;

	typedef logic [`AOSC_ADDR_W-1:0] aosc_addr_t;
	typedef logic [7:0] aosc_byte_t;

	typedef enum logic [1:0] {
		AOSC_PWR_ON = 2'h0,
		AOSC_PWR_DOWN = 2'h1,
		AOSC_PWR_STANDBY = 2'h2,
		AOSC_PWR_DIGRST = 2'h3
	} aosc_power_t;

	typedef enum logic [2:0] {
		AOSC_LANE_SDR_BIT = 3'h0,
		AOSC_LANE_SDR_BYTE = 3'h1,
		AOSC_LANE_DDR_BIT = 3'h2,
		AOSC_LANE_DDR_BYTE = 3'h3,
		AOSC_LANE_DDR_WORD = 3'h4,
		AOSC_LANE_INVALID = 3'h7
	} aosc_lane_t;

	// Host sequencer states, one-hot
	typedef enum logic [4:0] {
		AOSC_H_IDLE = 5'h01,
		AOSC_H_SOFT = 5'h02,
		AOSC_H_DIGRST = 5'h04,
		AOSC_H_NORMAL = 5'h08,
		AOSC_H_SINGLE = 5'h10
	} aosc_host_state_t;

endpackage

// ### verif/aosc_link_chk.sv
/*
 * Checker for the register link between host end and configuration bank.
 * Assumes one clock, a synchronous active-low reset and signals of aosc_link_if.
 */
`timescale 1ns/1ps

module aosc_link_chk
	import aosc_pkg::*;
	(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire aosc_addr_t addr,
	input wire aosc_byte_t wr_data,
	input wire aosc_byte_t rd_data,
	input wire logic rd_valid
	);

	// ****************************************
	// Link properties
	// ****************************************
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_soft;
		wr_en && addr == 13'h000 && wr_data == 8'h3C;
	endsequence

	sequence s_dig_go;
		wr_en && addr == 13'h008 && wr_data == 8'h03;
	endsequence

	sequence s_dig_end;
		wr_en && addr == 13'h008 && wr_data == 8'h00;
	endsequence

	sequence s_dig;
		s_dig_go ##1 s_dig_end;
	endsequence

	a_read_answer: assert property (1 |=> rd_valid == $past(rd_en))
		else $error("read answer not one cycle after strobe");
	a_rd_idle_zero: assert property (!rd_valid |-> rd_data == 8'h00)
		else $error("read data not zero outside answer");
	a_io_two_open: assert property (rd_en && addr == 13'h101 |=> rd_data[7:1] == 7'h00)
		else $error("open bits of io control two read nonzero");
	a_io_three_open: assert property (rd_en && addr == 13'h102 |=> (rd_data & 8'hF7) == 8'h00)
		else $error("open bits of io control three read nonzero");
	a_xfer_reads_zero: assert property (rd_en && (addr == 13'h000 || addr == 13'h0FF)
		|=> rd_data == 8'h00)
		else $error("command register read nonzero");
	a_one_strobe: assert property (!(wr_en && rd_en))
		else $error("write and read strobe together");
	a_supply_order: assert property (s_soft |=> s_dig)
		else $error("soft reset not followed by digital reset pair");
	a_clock_order: assert property (s_dig_go |=> s_dig_end)
		else $error("digital reset not followed by normal mode");
	a_soft_default: assert property (s_soft ##1 s_dig ##[1:6] (rd_en && addr == 13'h021)
		|=> rd_data == 8'h32)
		else $error("serial mode not default after soft reset");

endmodule // aosc_link_chk

// ### verif/testbench.sv
/*
 * Self-checking bench: host end and configuration bank joined by the link.
 * Assumes design files under hw/ and the checker compiled before this file.
 */
`timescale 1ns/1ps

module testbench;
	import aosc_pkg::*;

	// ****************************************
	// Stimulus and instances
	// ****************************************
	logic core_clk_in = 0, rst_n_in = 0, req_valid_in = 0, req_write_in = 0;
	logic recover_supply_in = 0, recover_clock_in = 0, req_ready_out, rsp_valid_out;
	logic [12:0] req_addr_in = 0;
	logic [7:0] req_data_in = 0, rsp_data_out, rate_override_out, q;
	logic [2:0] rate_cap_out;
	logic [3:0] clk_mult_x2_out;
	logic sdio_pulldown_en_out, vcm_powerdown_out, sample_is_12bit_out, frame_2x_out;
	logic datapath_reset_out, datapath_enable_out, init_done_out, seen;
	aosc_lane_t lane_mode_out;
	aosc_power_t power_mode_out;
	int err_total = 0, samples_checked = 0, cyc = 0;
	logic [7:0] codes [18] = '{8'h32, 8'h22, 8'h12, 8'h02, 8'h36, 8'h26, 8'h16, 8'h06, 8'h42,
		8'h33, 8'h23, 8'h13, 8'h03, 8'h37, 8'h27, 8'h17, 8'h07, 8'h43};

	always #25 core_clk_in = ~core_clk_in;

	aosc_link_if aosc_link_if_inst (.clk(core_clk_in));
	aosc_host aosc_host_inst (.core_clk_in, .rst_n_in, .link(aosc_link_if_inst), .req_valid_in, .req_write_in,
		.req_addr_in, .req_data_in, .recover_supply_in, .recover_clock_in, .req_ready_out, .rsp_data_out,
		.rsp_valid_out);
	aosc_device aosc_device_inst (.core_clk_in, .rst_n_in, .link(aosc_link_if_inst), .rate_override_out,
		.rate_cap_out, .sdio_pulldown_en_out, .vcm_powerdown_out, .sample_is_12bit_out, .frame_2x_out,
		.lane_mode_out, .clk_mult_x2_out, .power_mode_out, .datapath_reset_out, .datapath_enable_out,
		.init_done_out);
	aosc_link_chk aosc_link_chk_inst (.core_clk_in, .rst_n_in, .wr_en(aosc_link_if_inst.wr_en),
		.rd_en(aosc_link_if_inst.rd_en), .addr(aosc_link_if_inst.addr), .wr_data(aosc_link_if_inst.wr_data),
		.rd_data(aosc_link_if_inst.rd_data), .rd_valid(aosc_link_if_inst.rd_valid));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	// Waits up to 8 cycles for ready first so a request is not dropped while the host is busy
	task automatic issue(input logic w, input logic [12:0] a, input logic [7:0] d);
		for (int i = 0; i < 8 && req_ready_out !== 1'b1; i++) begin
			@(posedge core_clk_in);
			#2;
		end
		req_valid_in = 1;
		req_write_in = w;
		req_addr_in = a;
		req_data_in = d;
		@(posedge core_clk_in);
		#2;
		req_valid_in = 0;
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		issue(1, a, d);
		repeat (3) @(posedge core_clk_in);
		#2;
	endtask

	task automatic rd(input logic [12:0] a, output logic [7:0] r);
		r = 8'hXX;
		issue(0, a, 8'h00);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk_in);
			#2;
			if (rsp_valid_out === 1'b1) begin
				r = rsp_data_out;
				break;
			end
		end
	endtask

	task automatic recover(input logic sup);
		seen = 0;
		if (sup) recover_supply_in = 1;
		else recover_clock_in = 1;
		@(posedge core_clk_in);
		#2;
		recover_supply_in = 0;
		recover_clock_in = 0;
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk_in);
			#2;
			if (datapath_reset_out === 1'b1) seen = 1;
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_values;
		rd(13'h021, q);
		chk("serial mode", q, 8'h32);
		chk("lane", {5'h00, lane_mode_out}, 8'h03);
		chk("mult", {4'h0, clk_mult_x2_out}, 8'h06);
		chk("pulldown", {7'h00, sdio_pulldown_en_out}, 8'h01);
		rd(13'h005, q);
		chk("unmapped", q, 8'h00);
		rd(13'h0FF, q);
		chk("transfer read", q, 8'h00);
	endtask

	task automatic t_serial_table;
		logic [7:0] c;
		logic [3:0] m;
		foreach (codes[i]) begin
			c = codes[i];
			m = c[0] ? (c[5] ? 4'h5 : 4'hA) : (c[5] ? 4'h6 : 4'hC);
			wr(13'h021, c);
			chk("width", {7'h00, sample_is_12bit_out}, {7'h00, ~c[0]});
			chk("frame", {7'h00, frame_2x_out}, {7'h00, c[2]});
			chk("lane", {5'h00, lane_mode_out}, {5'h00, c[6:4]});
			chk("mult", {4'h0, clk_mult_x2_out}, {4'h0, m});
			rd(13'h021, q);
			chk("serial readback", q, c);
		end
	endtask

	task automatic t_override;
		wr(13'h100, 8'hA5);
		chk("override pending", rate_override_out, 8'h00);
		wr(13'h0FF, 8'h01);
		chk("override commit", rate_override_out, 8'hA5);
		chk("rate cap", {5'h00, rate_cap_out}, 8'h05);
		// Last table entry was 10-bit one-lane, whose clock multiple the cap must not touch
		chk("rate kept", {4'h0, clk_mult_x2_out}, 8'h0A);
	endtask

	task automatic t_io;
		wr(13'h101, 8'hFF);
		chk("pulldown off", {7'h00, sdio_pulldown_en_out}, 8'h00);
		rd(13'h101, q);
		chk("io two", q, 8'h01);
		wr(13'h102, 8'hFF);
		chk("vcm off", {7'h00, vcm_powerdown_out}, 8'h01);
		rd(13'h102, q);
		chk("io three", q, 8'h08);
		wr(13'h102, 8'h00);
		chk("vcm on", {7'h00, vcm_powerdown_out}, 8'h00);
	endtask

	// Clock recovery must leave register values alone, supply recovery restores defaults
	task automatic t_recovery;
		recover(0);
		chk("dig reset seen", {7'h00, seen}, 8'h01);
		rd(13'h101, q);
		chk("regs kept", q, 8'h01);
		chk("power mode", {6'h00, power_mode_out}, 8'h00);
		chk("enabled", {7'h00, datapath_enable_out}, 8'h01);
		recover(1);
		chk("supply reset seen", {7'h00, seen}, 8'h01);
		rd(13'h021, q);
		chk("soft default", q, 8'h32);
		chk("pulldown back", {7'h00, sdio_pulldown_en_out}, 8'h01);
		chk("init done", {7'h00, init_done_out}, 8'h01);
	endtask

	// Power-down, standby, an off-table layout, then a reset in mid-run
	task automatic t_power;
		wr(13'h008, 8'hFD);
		rd(13'h008, q);
		chk("power open bits", q, 8'h01);
		chk("power down reset", {7'h00, datapath_reset_out}, 8'h01);
		wr(13'h008, 8'h02);
		chk("standby mode", {6'h00, power_mode_out}, 8'h02);
		chk("standby off", {7'h00, datapath_enable_out}, 8'h00);
		wr(13'h021, 8'h52);
		chk("bad layout", {5'h00, lane_mode_out}, 8'h07);
		wr(13'h008, 8'h00);
		rst_n_in = 0;
		repeat (2) @(posedge core_clk_in);
		#2;
		chk("reset datapath", {7'h00, datapath_reset_out}, 8'h01);
		chk("reset init", {7'h00, init_done_out}, 8'h00);
		rst_n_in = 1;
		rd(13'h021, q);
		chk("reset default", q, 8'h32);
	endtask

	// ****************************************
	// Run control
	// ****************************************
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	initial begin
		repeat (12) @(posedge core_clk_in);
		#2;
		rst_n_in = 1;
		t_reset_values();
		t_serial_table();
		t_override();
		t_io();
		t_recovery();
		t_power();
		close_out();
	end

endmodule // testbench
